// ### pcr_config_bank.sv
// Configuration and status bank for two loop channels, byte registers.
// Assumes a same-clock master on the register port; alarm, status and step
// request pins come from outside and are synchronised here.
//
// What this block does
// RULE1: Alarm mask: loss bits 0-3, frequency bits 4-7.
// RULE2: Mask 0 passes alarm, 1 hides it.
// RULE3: Inputs 0/1 ranks at bits 2:0, 6:4.
// RULE4: Inputs 2/3 ranks, same coding, next register.
// RULE5: Software keeps switch mode 2, companion 0.
// RULE6: History valid bit reads true history state.
// RULE7: Fastlock status bit reads fastlock in use.
// RULE8: Input loss stops history accumulation.
// RULE9: Valid input clears and restarts history.
// RULE10: Channel B active input reads at 7:6.
// RULE11: Bandwidth sets apply on strobe or full reset.
// RULE12: Channel-only soft reset applies no bandwidth.
// RULE13: Apply bit 1 loads both sets; 0 nothing.
// RULE14: Numerator 56 bits, seven bytes, LSB first.
// RULE15: Denominator 32 bits, four bytes, LSB first.
// RULE16: Divider changes act only on apply bit.
// RULE17: Divider apply bits 7:1 accept anything.
// RULE18: Software sets fraction mode 0xB, bit5 one.
// RULE19: Fraction enable: 0 integer, 1 fractional.
// RULE20: Step mask 0 enables, 1 blocks steps.
// RULE21: Increment adds step word, decrement subtracts.
// RULE22: Phase threshold ten bits over two registers.
// RULE23: Each accepted request steps exactly once.
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_config_bank #(
  parameter logic [15:0] HIST_TARGET = `PCR_HIST_TARGET
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [`PCR_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [7:0]              reg_rdata_out,
  input  wire logic [3:0]              signal_loss_alarm_in,
  input  wire logic [3:0]              off_frequency_alarm_in,
  input  wire logic                    chan_a_input_valid_in,
  input  wire logic                    chan_a_fast_acquire_in,
  input  wire logic                    frequency_increment_request_in,
  input  wire logic                    frequency_decrement_request_in,
  input  wire logic [1:0]              chan_b_active_input_in,
  input  wire logic                    full_soft_reset_in,
  output logic      [3:0]              chan_a_qualified_alarm_out,
  output logic      [11:0]             chan_a_input_rank_out,
  output logic      [9:0]              chan_a_switch_phase_threshold_out,
  output logic                         chan_a_holdover_entry_out,
  output logic                         chan_a_freerun_entry_out,
  output logic      [47:0]             chan_b_loop_bandwidth_out,
  output logic      [47:0]             chan_b_fastlock_bandwidth_out,
  output logic      [55:0]             chan_b_feedback_numerator_out,
  output logic      [31:0]             chan_b_feedback_denominator_out,
  output logic                         chan_b_fractional_enable_out
);

  localparam logic [7:0] IDX_MASK   = 8'(`PCR_OFS_ALARM_MASK - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_PRIO   = 8'(`PCR_OFS_PRIO01 - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_THR    = 8'(`PCR_OFS_THR_LO - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_BW     = 8'(`PCR_OFS_B_BW - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_FBW    = 8'(`PCR_OFS_B_FAST_BW - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_NUM    = 8'(`PCR_OFS_B_NUM - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_DEN    = 8'(`PCR_OFS_B_DEN - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_FRAC   = 8'(`PCR_OFS_B_FRAC - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_STEPC  = 8'(`PCR_OFS_B_STEP_CTL - `PCR_OFS_BASE);
  localparam logic [7:0] IDX_STEP   = 8'(`PCR_OFS_B_STEP - `PCR_OFS_BASE);

  // Byte storage for every read/write register; unwritable bits stay zero
  pcr_pkg::pcr_byte_t cfg_reg [0:`PCR_SPAN-1];
  logic [7:0]  idx;
  logic        in_range;
  logic [13:0] sync_s1_reg;
  logic [13:0] sync_s2_reg;
  logic [2:0]  edge_s3_reg;
  logic [3:0]  los_s2;
  logic [3:0]  oof_s2;
  logic        ok_s2;
  logic        fast_s2;
  logic        inc_s2;
  logic        dec_s2;
  logic [1:0]  act_s2;
  logic        ok_rise;
  logic        ok_fall;
  logic        inc_rise;
  logic        dec_rise;
  logic [15:0] hist_cnt_reg;
  logic        hist_valid;
  logic [47:0] bw_stage;
  logic [47:0] fbw_stage;
  logic [55:0] num_stage;
  logic [31:0] den_stage;
  logic [55:0] step_word;
  logic        step_masked;
  logic        bw_apply_go;
  logic        div_apply_go;
  pcr_pkg::pcr_step_e step_kind;

  // Writable bits per address; zero marks read-only, strobe or unmapped bytes
  function automatic logic [7:0] wmask(input logic [`PCR_ADDR_W-1:0] a);
    case (a) inside
      `PCR_OFS_ALARM_MASK:                           wmask = `PCR_MASK_FULL;
      `PCR_OFS_PRIO01, `PCR_OFS_PRIO23:              wmask = `PCR_MASK_PRIO;
      `PCR_OFS_HSW_MODE, `PCR_OFS_FINE_LEN,
      `PCR_OFS_RAMP:                                 wmask = `PCR_MASK_LOW4;
      `PCR_OFS_THR_LO, `PCR_OFS_B_NUM_HI:            wmask = `PCR_MASK_FULL;
      `PCR_OFS_THR_HI, `PCR_OFS_FINE_ADJ_HI,
      `PCR_OFS_B_STEP_CTL:                           wmask = `PCR_MASK_LOW2;
      `PCR_OFS_COARSE_LEN, `PCR_OFS_COARSE_DLY,
      `PCR_OFS_DET_DLY_HI:                           wmask = `PCR_MASK_LOW5;
      `PCR_OFS_FORCE_FINE:                           wmask = `PCR_MASK_FORCE;
      `PCR_OFS_HO_EXIT_CTL:                          wmask = `PCR_MASK_HO_CTL;
      [`PCR_OFS_FINE_ADJ:`PCR_OFS_FINE_ADJ_HI-12'h1],
      `PCR_OFS_DET_DLY,
      [`PCR_OFS_HO_EXIT_BW:`PCR_OFS_HO_EXIT_BW_HI],
      [`PCR_OFS_B_NUM:`PCR_OFS_B_DEN_HI],
      [`PCR_OFS_B_STEP:`PCR_OFS_B_STEP_HI]:          wmask = `PCR_MASK_FULL;
      [`PCR_OFS_B_BW:`PCR_OFS_B_FAST_BW_HI],
      `PCR_OFS_B_FRAC:                               wmask = `PCR_MASK_BW;
      default:                                       wmask = `PCR_MASK_NONE;
    endcase
  endfunction

  // Address decode into the storage array
  assign idx      = 8'(reg_addr_in - `PCR_OFS_BASE);
  assign in_range = (reg_addr_in >= `PCR_OFS_BASE) && (reg_addr_in <= `PCR_OFS_B_STEP_HI);

  // Pin inputs pass two flops; only the second stage and later feed logic
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_s1_reg <= 14'h0000;
      sync_s2_reg <= 14'h0000;
      edge_s3_reg <= 3'h0;
    end else begin
      sync_s1_reg <= {signal_loss_alarm_in, off_frequency_alarm_in, chan_a_input_valid_in,
                      chan_a_fast_acquire_in, frequency_increment_request_in,
                      frequency_decrement_request_in, chan_b_active_input_in};
      sync_s2_reg <= sync_s1_reg;
      edge_s3_reg <= {sync_s2_reg[5], sync_s2_reg[3:2]};
    end
  end

  assign los_s2   = sync_s2_reg[13:10];
  assign oof_s2   = sync_s2_reg[9:6];
  assign ok_s2    = sync_s2_reg[5];
  assign fast_s2  = sync_s2_reg[4];
  assign inc_s2   = sync_s2_reg[3];
  assign dec_s2   = sync_s2_reg[2];
  assign act_s2   = sync_s2_reg[1:0];
  // Edges keep a held request pin from stepping more than once
  assign ok_rise  = ok_s2 && !edge_s3_reg[2];
  assign ok_fall  = !ok_s2 && edge_s3_reg[2];
  assign inc_rise = inc_s2 && !edge_s3_reg[1];
  assign dec_rise = dec_s2 && !edge_s3_reg[0];

  // Register writes; each stored byte keeps only its defined bits
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `PCR_SPAN; i++) begin
        cfg_reg[i] <= `PCR_RST_ZERO;
      end
      cfg_reg[8'(`PCR_OFS_HSW_MODE - `PCR_OFS_BASE)] <= `PCR_RST_HSW_MODE;
      cfg_reg[IDX_FRAC] <= `PCR_RST_FRAC;
    end else if (reg_wr_in && in_range) begin
      cfg_reg[idx] <= reg_wdata_in & wmask(reg_addr_in); // RULE1 RULE17
    end
  end

  // Multi-byte staged values, least significant byte at the lowest address
  always_comb begin
    bw_stage  = 48'h0;
    fbw_stage = 48'h0;
    num_stage = 56'h0;
    den_stage = 32'h0;
    step_word = 56'h0;
    for (int k = 0; k < 7; k++) begin
      num_stage[k*8 +: 8] = cfg_reg[IDX_NUM + 8'(k)];  // RULE14
      step_word[k*8 +: 8] = cfg_reg[IDX_STEP + 8'(k)];
    end
    for (int k = 0; k < 6; k++) begin
      bw_stage[k*8 +: 8]  = cfg_reg[IDX_BW + 8'(k)];
      fbw_stage[k*8 +: 8] = cfg_reg[IDX_FBW + 8'(k)];
    end
    for (int k = 0; k < 4; k++) begin
      den_stage[k*8 +: 8] = cfg_reg[IDX_DEN + 8'(k)];  // RULE15
    end
  end

  assign step_masked  = cfg_reg[IDX_STEPC][`PCR_BIT_STEP_MASK];
  // Only the full-device reset applies bandwidth; a channel reset is not an input here
  assign bw_apply_go  = (reg_wr_in && reg_addr_in == `PCR_OFS_B_BW_APPLY
                         && reg_wdata_in[`PCR_BIT_APPLY]) // RULE13
                        || full_soft_reset_in; // RULE11 RULE12
  // Bits 7:1 of the divider strobe are ignored
  assign div_apply_go = reg_wr_in && reg_addr_in == `PCR_OFS_B_DIV_APPLY
                        && reg_wdata_in[`PCR_BIT_APPLY]; // RULE16 RULE17

  // Simultaneous increment and decrement cancel rather than guess an order
  always_comb begin
    if (inc_rise && !dec_rise) begin
      step_kind = pcr_pkg::PCR_STEP_INC;
    end else if (dec_rise && !inc_rise) begin
      step_kind = pcr_pkg::PCR_STEP_DEC;
    end else begin
      step_kind = pcr_pkg::PCR_STEP_IDLE;
    end
  end

  // Active bandwidth sets load only on an apply event
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_b_loop_bandwidth_out     <= 48'h0;
      chan_b_fastlock_bandwidth_out <= 48'h0;
    end else if (bw_apply_go) begin
      chan_b_loop_bandwidth_out     <= bw_stage;  // RULE11 RULE13
      chan_b_fastlock_bandwidth_out <= fbw_stage; // RULE13
    end
  end

  // Active divider: apply wins over a step arriving in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_b_feedback_numerator_out   <= 56'h0;
      chan_b_feedback_denominator_out <= 32'h0;
    end else if (div_apply_go) begin
      chan_b_feedback_numerator_out   <= num_stage; // RULE16
      chan_b_feedback_denominator_out <= den_stage; // RULE16
    end else if (!step_masked) begin // RULE20
      case (step_kind)
        pcr_pkg::PCR_STEP_INC: begin // RULE21 RULE23
          chan_b_feedback_numerator_out <= chan_b_feedback_numerator_out + step_word;
        end
        pcr_pkg::PCR_STEP_DEC: begin // RULE21 RULE23
          chan_b_feedback_numerator_out <= chan_b_feedback_numerator_out - step_word;
        end
        default: begin
          chan_b_feedback_numerator_out <= chan_b_feedback_numerator_out;
        end
      endcase
    end
  end

  // History counter freezes while the input is bad, restarts on its return
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hist_cnt_reg <= 16'h0000;
    end else if (ok_rise) begin
      hist_cnt_reg <= 16'h0000; // RULE9
    end else if (ok_s2 && hist_cnt_reg != HIST_TARGET) begin
      hist_cnt_reg <= hist_cnt_reg + 16'h0001; // RULE8
    end
  end

  assign hist_valid = (hist_cnt_reg == HIST_TARGET); // RULE6

  // Loss of the selected input picks holdover or free-run from history state
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_a_holdover_entry_out <= 1'b0;
      chan_a_freerun_entry_out  <= 1'b0;
    end else begin
      chan_a_holdover_entry_out <= ok_fall && hist_valid;  // RULE6 RULE8
      chan_a_freerun_entry_out  <= ok_fall && !hist_valid; // RULE6
    end
  end

  // Configuration outputs; reserved ranks 5-7 are treated as no rank
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_a_qualified_alarm_out        <= 4'h0;
      chan_a_input_rank_out             <= 12'h000;
      chan_a_switch_phase_threshold_out <= 10'h000;
      chan_b_fractional_enable_out      <= 1'b0;
    end else begin
      chan_a_qualified_alarm_out <= (los_s2 & ~cfg_reg[IDX_MASK][3:0])
                                  | (oof_s2 & ~cfg_reg[IDX_MASK][`PCR_OOF_LSB +: 4]); // RULE2
      for (int i = 0; i < 4; i++) begin
        chan_a_input_rank_out[i*3 +: 3] <=
          (cfg_reg[IDX_PRIO + 8'(i/2)][(i%2)*4 +: 3] > `PCR_RANK_MAX) ? `PCR_RANK_NONE
          : cfg_reg[IDX_PRIO + 8'(i/2)][(i%2)*4 +: 3]; // RULE3 RULE4
      end
      chan_a_switch_phase_threshold_out <= {cfg_reg[IDX_THR + 8'h1][1:0],
                                            cfg_reg[IDX_THR]}; // RULE22
      chan_b_fractional_enable_out <= cfg_reg[IDX_FRAC][`PCR_BIT_FRAC_EN]; // RULE19
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_addr_in == `PCR_OFS_HIST_STAT) begin
      reg_rdata_out <= {5'h00, fast_s2, hist_valid, 1'b0}; // RULE6 RULE7
    end else if (reg_addr_in == `PCR_OFS_B_ACTIVE) begin
      reg_rdata_out <= {act_s2, 6'h00}; // RULE10
    end else if (in_range) begin
      reg_rdata_out <= cfg_reg[idx];
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_MASK_WRITE: assert property ( // RULE1
    reg_wr_in && reg_addr_in == `PCR_OFS_ALARM_MASK |=> cfg_reg[IDX_MASK] == $past(reg_wdata_in))
    else $error("alarm mask write not stored");
  AST_MASK_HIDES: assert property ( // RULE2
    cfg_reg[IDX_MASK][0] && !oof_s2[0] |=> !chan_a_qualified_alarm_out[0])
    else $error("masked alarm reached selection");
  AST_RANK_RESERVED: assert property ( // RULE3
    reg_wr_in && reg_addr_in == `PCR_OFS_PRIO01 && reg_wdata_in[2:0] > 3'h4
    |-> ##2 chan_a_input_rank_out[2:0] == 3'h0)
    else $error("reserved rank not treated as none");
  AST_RANK3_VALUE: assert property ( // RULE4
    reg_wr_in && reg_addr_in == `PCR_OFS_PRIO23 && reg_wdata_in[6:4] <= 3'h4
    ##1 !(reg_wr_in && reg_addr_in == `PCR_OFS_PRIO23)
    |=> chan_a_input_rank_out[11:9] == $past(reg_wdata_in[6:4], 2))
    else $error("input 3 rank wrong");
  AST_HIST_READ: assert property ( // RULE6
    reg_rd_in && reg_addr_in == `PCR_OFS_HIST_STAT |=> reg_rdata_out[1] == $past(hist_valid))
    else $error("history valid readback wrong");
  AST_FAST_READ: assert property ( // RULE7
    reg_rd_in && reg_addr_in == `PCR_OFS_HIST_STAT |=> reg_rdata_out[2] == $past(fast_s2))
    else $error("fastlock status readback wrong");
  AST_HIST_FREEZE: assert property ( // RULE8
    !ok_s2 |=> hist_cnt_reg == $past(hist_cnt_reg))
    else $error("history accumulated without input");
  AST_HIST_RESTART: assert property ( // RULE9
    ok_rise |=> hist_cnt_reg == 16'h0000 ##1 hist_cnt_reg <= 16'h0001)
    else $error("history not restarted");
  AST_ACTIVE_READ: assert property ( // RULE10
    reg_rd_in && reg_addr_in == `PCR_OFS_B_ACTIVE |=> reg_rdata_out == {$past(act_s2), 6'h00})
    else $error("active input readback wrong");
  AST_BW_APPLY: assert property ( // RULE11
    bw_apply_go |=> chan_b_loop_bandwidth_out == $past(bw_stage))
    else $error("bandwidth not applied");
  AST_BW_HOLD: assert property ( // RULE12
    !bw_apply_go |=> $stable(chan_b_loop_bandwidth_out))
    else $error("bandwidth changed without apply");
  AST_BW_ZERO_WRITE: assert property ( // RULE13
    reg_wr_in && reg_addr_in == `PCR_OFS_B_BW_APPLY && !reg_wdata_in[0] && !full_soft_reset_in
    |=> $stable(chan_b_fastlock_bandwidth_out))
    else $error("apply bit zero changed fastlock set");
  AST_NUM_TOP_BYTE: assert property ( // RULE14
    reg_wr_in && reg_addr_in == `PCR_OFS_B_NUM_HI |=> num_stage[55:48] == $past(reg_wdata_in))
    else $error("numerator top byte misplaced");
  AST_DEN_TOP_BYTE: assert property ( // RULE15
    reg_wr_in && reg_addr_in == `PCR_OFS_B_DEN_HI |=> den_stage[31:24] == $past(reg_wdata_in))
    else $error("denominator top byte misplaced");
  AST_DEN_HOLD: assert property ( // RULE16
    !div_apply_go |=> $stable(chan_b_feedback_denominator_out))
    else $error("denominator changed without apply");
  AST_DIV_APPLY_ANY: assert property ( // RULE17
    reg_wr_in && reg_addr_in == `PCR_OFS_B_DIV_APPLY && reg_wdata_in[0]
    |=> chan_b_feedback_numerator_out == $past(num_stage))
    else $error("divider apply ignored");
  AST_FRAC_EN: assert property ( // RULE19
    reg_wr_in && reg_addr_in == `PCR_OFS_B_FRAC ##1 !(reg_wr_in && reg_addr_in == `PCR_OFS_B_FRAC)
    |=> chan_b_fractional_enable_out == $past(reg_wdata_in[4], 2))
    else $error("fraction enable wrong");
  AST_STEP_MASKED: assert property ( // RULE20
    step_masked && !div_apply_go |=> $stable(chan_b_feedback_numerator_out))
    else $error("step passed while masked");
  AST_STEP_INC: assert property ( // RULE21
    step_kind == pcr_pkg::PCR_STEP_INC && !step_masked && !div_apply_go
    |=> chan_b_feedback_numerator_out == $past(chan_b_feedback_numerator_out) + $past(step_word))
    else $error("increment not added");
  AST_THR_HIGH: assert property ( // RULE22
    reg_wr_in && reg_addr_in == `PCR_OFS_THR_HI ##1 !(reg_wr_in && reg_addr_in == `PCR_OFS_THR_HI)
    |=> chan_a_switch_phase_threshold_out[9:8] == $past(reg_wdata_in[1:0], 2))
    else $error("threshold high bits wrong");
  AST_STEP_ONCE: assert property ( // RULE23
    step_kind != pcr_pkg::PCR_STEP_IDLE |=> step_kind == pcr_pkg::PCR_STEP_IDLE)
    else $error("one request stepped twice");

  COV_INC_STEP: cover property (step_kind == pcr_pkg::PCR_STEP_INC && !step_masked);
  COV_DEC_STEP: cover property (step_kind == pcr_pkg::PCR_STEP_DEC && !step_masked);
  COV_DIV_APPLY: cover property (div_apply_go);
  COV_HOLDOVER: cover property (chan_a_holdover_entry_out);

endmodule

// ### pcr_pkg.sv
// Types shared by the loop configuration bank.
// Assumes nothing beyond a SystemVerilog-capable tool.
package pcr_pkg;
  typedef enum logic [2:0] {
    PCR_STEP_IDLE = 3'h1,
    PCR_STEP_INC  = 3'h2,
    PCR_STEP_DEC  = 3'h4
  } pcr_step_e;
  typedef logic [7:0] pcr_byte_t;
endpackage

// ### pcr_regs.svh
// Register offsets, writable-bit masks, field positions and reset values
// for the two-channel loop configuration bank.
// Assumes a byte-wide register port with 12-bit byte addresses.
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

`define PCR_ADDR_W            12
`define PCR_OFS_BASE          12'h437
`define PCR_SPAN              243
`define PCR_OFS_ALARM_MASK    12'h437
`define PCR_OFS_PRIO01        12'h438
`define PCR_OFS_PRIO23        12'h439
`define PCR_OFS_HSW_MODE      12'h43A
`define PCR_OFS_THR_LO        12'h43B
`define PCR_OFS_THR_HI        12'h43C
`define PCR_OFS_COARSE_LEN    12'h43D
`define PCR_OFS_COARSE_DLY    12'h43E
`define PCR_OFS_HIST_STAT     12'h43F
`define PCR_OFS_FINE_ADJ      12'h442
`define PCR_OFS_FINE_ADJ_HI   12'h444
`define PCR_OFS_FORCE_FINE    12'h445
`define PCR_OFS_FINE_LEN      12'h488
`define PCR_OFS_DET_DLY       12'h489
`define PCR_OFS_DET_DLY_HI    12'h48A
`define PCR_OFS_HO_EXIT_CTL   12'h49B
`define PCR_OFS_HO_EXIT_BW    12'h49D
`define PCR_OFS_HO_EXIT_BW_HI 12'h4A2
`define PCR_OFS_RAMP          12'h4A6
`define PCR_OFS_B_ACTIVE      12'h507
`define PCR_OFS_B_BW          12'h508
`define PCR_OFS_B_FAST_BW     12'h50E
`define PCR_OFS_B_FAST_BW_HI  12'h513
`define PCR_OFS_B_BW_APPLY    12'h514
`define PCR_OFS_B_NUM         12'h515
`define PCR_OFS_B_NUM_HI      12'h51B
`define PCR_OFS_B_DEN         12'h51C
`define PCR_OFS_B_DEN_HI      12'h51F
`define PCR_OFS_B_DIV_APPLY   12'h520
`define PCR_OFS_B_FRAC        12'h521
`define PCR_OFS_B_STEP_CTL    12'h522
`define PCR_OFS_B_STEP        12'h523
`define PCR_OFS_B_STEP_HI     12'h529

`define PCR_MASK_FULL         8'hFF
`define PCR_MASK_PRIO         8'h77
`define PCR_MASK_LOW4         8'h0F
`define PCR_MASK_LOW5         8'h1F
`define PCR_MASK_LOW2         8'h03
`define PCR_MASK_FORCE        8'h02
`define PCR_MASK_HO_CTL       8'hF6
`define PCR_MASK_BW           8'h3F
`define PCR_MASK_NONE         8'h00

`define PCR_RST_HSW_MODE      8'h02
`define PCR_RST_FRAC          8'h2B
`define PCR_RST_ZERO          8'h00

`define PCR_BIT_HIST_VALID    1
`define PCR_BIT_FASTLOCK      2
`define PCR_BIT_APPLY         0
`define PCR_BIT_FRAC_EN       4
`define PCR_BIT_STEP_MASK     0
`define PCR_OOF_LSB           4
`define PCR_RANK_MAX          3'h4
`define PCR_RANK_NONE         3'h0
`define PCR_HIST_TARGET       16'h0400

`endif

// ### tb_pcr_config_bank.sv
// Self-checking bench for the two-channel loop configuration bank.
// Assumes the bank's header and package are compiled first; no far-side model.
`timescale 1ns/1ps
module tb_pcr_config_bank;
  logic        clk, rst_n, ws, rs, fsr, vld, fst, inc, dec, ho, fr, fen;
  logic [11:0] ad, rank;
  logic [7:0]  wd, rdat;
  logic [3:0]  signal_loss_alarm, off_frequency_alarm, qal;
  logic [1:0]  act;
  logic [9:0]  thr;
  logic [47:0] bw, fbw;
  logic [55:0] num;
  logic [31:0] den;
  int          err_total, tests_run, hc, fc;

  // Short history target keeps the holdover checks quick
  pcr_config_bank #(.HIST_TARGET(16'h0008)) DUT (
    .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(ad), .reg_wdata_in(wd),
    .reg_wr_in(ws), .reg_rd_in(rs), .reg_rdata_out(rdat),
    .signal_loss_alarm_in(signal_loss_alarm), .off_frequency_alarm_in(off_frequency_alarm),
    .chan_a_input_valid_in(vld), .chan_a_fast_acquire_in(fst),
    .frequency_increment_request_in(inc), .frequency_decrement_request_in(dec),
    .chan_b_active_input_in(act), .full_soft_reset_in(fsr),
    .chan_a_qualified_alarm_out(qal), .chan_a_input_rank_out(rank),
    .chan_a_switch_phase_threshold_out(thr), .chan_a_holdover_entry_out(ho),
    .chan_a_freerun_entry_out(fr), .chan_b_loop_bandwidth_out(bw),
    .chan_b_fastlock_bandwidth_out(fbw), .chan_b_feedback_numerator_out(num),
    .chan_b_feedback_denominator_out(den), .chan_b_fractional_enable_out(fen));

  // Clock and entry pulse counters
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    hc <= hc + int'(ho);
    fc <= fc + int'(fr);
  end

  task chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // cyc, rd and pulse end off the edge, wr ends on it; each drive starts at a fresh rising edge
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    ad <= a;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task pulse(input logic up);
    @(posedge clk);
    inc <= up;
    dec <= ~up;
    cyc(5);
    @(posedge clk);
    inc <= 1'b0;
    dec <= 1'b0;
    cyc(4);
  endtask

  task t_regs;
    rd(12'h43A, 8'h02);
    rd(12'h521, 8'h2B);
    chk(fen, 1'b0);
    wr(12'h507, 8'hFF);
    rd(12'h507, 8'h80);
    @(posedge clk) act <= 2'h1;
    cyc(3);
    rd(12'h507, 8'h40);
    wr(12'h600, 8'h5A);
    rd(12'h600, 8'h00);
    wr(12'h521, 8'h3B);
    wr(12'h43B, 8'hA5);
    wr(12'h43C, 8'hFE);
    cyc(2);
    chk(fen, 1'b1);
    chk(thr, 10'h2A5);
  endtask
  task t_alarm_rank;
    wr(12'h437, 8'h21);
    @(posedge clk) signal_loss_alarm <= 4'hF;
    cyc(4);
    chk(qal, 4'hE);
    @(posedge clk) signal_loss_alarm <= 4'h0;
    off_frequency_alarm <= 4'hF;
    cyc(4);
    chk(qal, 4'hD);
    wr(12'h438, 8'h41);
    wr(12'h439, 8'h53);
    cyc(2);
    chk(rank, 12'h0E1);
    rd(12'h439, 8'h53);
    wr(12'h438, 8'h07);
    wr(12'h439, 8'h24);
    cyc(2);
    chk(rank, 12'h500);
  endtask
  // Staged bandwidth stays out of use until a strobe or full reset
  task t_bw;
    wr(12'h508, 8'h15);
    wr(12'h50E, 8'h2A);
    wr(12'h514, 8'h00);
    cyc(2);
    chk(bw, 48'h0);
    wr(12'h514, 8'h01);
    cyc(2);
    chk(bw, 48'h15);
    chk(fbw, 48'h2A);
    wr(12'h509, 8'h3F);
    @(posedge clk) fsr <= 1'b1;
    @(posedge clk) fsr <= 1'b0;
    cyc(2);
    chk(bw, 48'h3F15);
  endtask
  task t_div_step;
    for (int i = 0; i < 7; i++) wr(12'h515 + 12'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++) wr(12'h51C + 12'(i), 8'(8'hA0 + i));
    rd(12'h51B, 8'h77);
    wr(12'h520, 8'hFE);
    cyc(2);
    chk(num, 56'h0);
    wr(12'h520, 8'hFF);
    cyc(2);
    chk(num, 56'h77665544332211);
    chk(den, 32'hA3A2A1A0);
    wr(12'h523, 8'h10);
    wr(12'h529, 8'h01);
    pulse(1'b1);
    chk(num, 56'h78665544332221);
    pulse(1'b1);
    chk(num, 56'h79665544332231);
    pulse(1'b0);
    chk(num, 56'h78665544332221);
    wr(12'h522, 8'h01);
    pulse(1'b1);
    chk(num, 56'h78665544332221);
  endtask
  // History fills, freezes on loss, restarts on a new valid input
  task t_hist;
    @(posedge clk) vld <= 1'b1;
    cyc(16);
    rd(12'h43F, 8'h02);
    @(posedge clk) vld <= 1'b0;
    cyc(6);
    chk(hc, 1);
    rd(12'h43F, 8'h02);
    @(posedge clk) vld <= 1'b1;
    cyc(2);
    rd(12'h43F, 8'h00);
    @(posedge clk) vld <= 1'b0;
    fst <= 1'b1;
    cyc(6);
    chk(fc, 1);
    rd(12'h43F, 8'h04);
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    {ws, rs, fsr, vld, fst, inc, dec, signal_loss_alarm, off_frequency_alarm} = '0;
    ad = '0;
    wd = '0;
    act = 2'h2;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_alarm_rank;
    t_bw;
    t_div_step;
    t_hist;
    stop_test;
  end
endmodule
